// File: logic/cpl_cfg.svh
// Constants for the colour palette lookup block
`ifndef CPL_CFG_SVH
`define CPL_CFG_SVH
`define CPL_SEL_IDX_WR  2'h0
`define CPL_SEL_PAL     2'h1
`define CPL_SEL_MASK    2'h2
`define CPL_SEL_IDX_RD  2'h3
`define CPL_PH_RED      2'h0
`define CPL_PH_GRN      2'h1
`define CPL_PH_BLU      2'h2
`define CPL_IDX_RST     8'h00
`define CPL_MASK_RST    8'hff
`define CPL_APB_CMD     12'h000
`define CPL_APB_STAT    12'h004
`define CPL_APB_RDATA   12'h008
`define CPL_STROBE_CYC  3'h3
`endif

// File: logic/cpl_pkg.sv
// Types shared by the colour palette lookup block
package cpl_pkg;
    typedef logic [1:0]  cpl_sel_t;
    typedef logic [17:0] cpl_entry_t;
    typedef enum logic [1:0] {CPL_H_IDLE, CPL_H_SETUP, CPL_H_STROBE, CPL_H_HOLD} cpl_hst_e;
endpackage

// File: logic/cpl_if.sv
// Host bus and pixel port joining the palette device and its host
`timescale 1ns/1ps
`default_nettype none
interface cpl_if;
    logic        target_select_lo;
    logic        target_select_hi;
    logic        rd_n;
    logic        wr_n;
    logic [7:0]  host_bus_to_dev;
    logic [7:0]  host_bus_to_host;
    logic        host_bus_oe_n;
    logic [7:0]  pixel_index_in;
    logic        blank_n;
    modport device (input target_select_lo, target_select_hi, rd_n, wr_n, host_bus_to_dev,
                    pixel_index_in, blank_n, output host_bus_to_host, host_bus_oe_n);
    modport host (output target_select_lo, target_select_hi, rd_n, wr_n, host_bus_to_dev,
                  pixel_index_in, blank_n, input host_bus_to_host, host_bus_oe_n);
endinterface
`default_nettype wire

// File: logic/cpl_sync.sv
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module cpl_sync #(parameter int W = 1)
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    // Shift chain, first stage read only by second
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s1_r <= '1;
            s2_r <= '1;
            s3_r <= '1;
        end
        else
        begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    // Output moves per bit once stages two and three agree
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            dout <= '1;
        else
            for (int i = 0; i < W; i++)
                if (s2_r[i] == s3_r[i])
                    dout[i] <= s3_r[i];
    end
endmodule // cpl_sync
`default_nettype wire

// File: logic/cpl_device.sv
// Palette lookup device: host register port, palette memory, pixel path
// Function
// [R1] Select lines pick index, palette or mask
// [R2] Blue write stores joined 18-bit entry
// [R3] Index advances after blue write
// [R4] Three reads return red, green, blue
// [R5] Colour on bits 0-5, upper zero
// [R6] Index wraps from FFH to 00H
// [R7] Host bus synchronised to pixel clock
// [R8] Host loads palette during blanking
// [R9] Hidden phase counts modulo three
// [R10] Index read changes no state
// [R11] Index write copies all eight bits
// [R12] Pixel index captured selects palette entry
// [R13] Blanking captured with the pixel
// [R14] Pixel index ANDed with mask
// [R15] Mask accessible any time undisturbed
// [R16] Blanking forces colour outputs black
// [R17] Pixel index ignored while blanking
// [R18] Write data taken at strobe rise
// [R19] Both strobes low is invalid
// [R20] Fixed pixel latency, blanking delayed equally
`timescale 1ns/1ps
`default_nettype none
`include "cpl_cfg.svh"
module cpl_device
(
    input  wire logic  CLOCK,
    input  wire logic  SYS_RST,
    cpl_if.device      BUS,
    output logic [5:0] RED_CODE,
    output logic [5:0] GREEN_CODE,
    output logic [5:0] BLUE_CODE
);
    cpl_pkg::cpl_entry_t palette_mem [256];
    logic [7:0]  palette_index_r;
    logic [7:0]  pixel_gate_mask_r;
    logic [1:0]  color_phase_r;
    logic        read_mode_r;
    logic [5:0]  red_hold_r;
    logic [5:0]  grn_hold_r;
    logic [17:0] rd_word_r;
    logic [7:0]  rd_byte_r;
    logic        oe_n_r;
    logic [11:0] s_in;
    logic [11:0] s_out;
    logic        wr_prev_r;
    logic        rd_prev_r;
    logic [7:0]  pix_r;
    logic        blank_n_r;
    logic [17:0] look_r;
    logic        blank_n_d_r;
    logic [7:0]  wdata;
    cpl_pkg::cpl_sel_t sel;
    logic        rd_n_s;
    logic        wr_n_s;
    logic        wr_done;
    logic        rd_start;
    logic        rd_done;
    logic        phase_blue;
    logic [1:0]  phase_nxt;

    // Index register addressed by either index select
    function automatic logic idx_sel(input cpl_pkg::cpl_sel_t s);
        idx_sel = (s == `CPL_SEL_IDX_WR) || (s == `CPL_SEL_IDX_RD);
    endfunction

    // [R7] Host pins synchronised
    assign s_in = {BUS.wr_n, BUS.rd_n, BUS.target_select_hi, BUS.target_select_lo,
                   BUS.host_bus_to_dev};
    cpl_sync #(.W(12)) u_sync (.clk(CLOCK), .rst(SYS_RST), .din(s_in), .dout(s_out));
    assign wdata  = s_out[7:0];
    assign sel    = s_out[9:8];
    assign rd_n_s = s_out[10];
    assign wr_n_s = s_out[11];

    // Strobe edge history
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            wr_prev_r <= 1'b1;
            rd_prev_r <= 1'b1;
        end
        else
        begin
            wr_prev_r <= wr_n_s;
            rd_prev_r <= rd_n_s;
        end
    end
    // [R18] Write on strobe rise; [R19] rejected with read low
    assign wr_done  = wr_n_s & ~wr_prev_r & rd_n_s;
    assign rd_start = ~rd_n_s & rd_prev_r & wr_n_s;
    assign rd_done  = rd_n_s & ~rd_prev_r & wr_n_s;
    assign phase_blue = (color_phase_r == `CPL_PH_BLU);
    // [R9] Modulo three step
    assign phase_nxt = phase_blue ? `CPL_PH_RED : 2'(color_phase_r + 2'h1);

    // [R9] Phase counter; [R10] index read leaves it
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
            color_phase_r <= `CPL_PH_RED;
        else if (wr_done && idx_sel(sel))
            color_phase_r <= `CPL_PH_RED;
        else if ((wr_done || rd_done) && sel == `CPL_SEL_PAL)
            color_phase_r <= phase_nxt;
    end

    // [R11] Index load; [R3] [R6] blue access advances with wrap
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            palette_index_r <= `CPL_IDX_RST;
            read_mode_r     <= 1'b0;
        end
        else if (wr_done && idx_sel(sel))
        begin
            palette_index_r <= wdata;
            read_mode_r     <= (sel == `CPL_SEL_IDX_RD);
        end
        else if ((wr_done || rd_done) && sel == `CPL_SEL_PAL && phase_blue)
            palette_index_r <= palette_index_r + 8'h01;
    end

    // [R1] [R15] Mask register
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
            pixel_gate_mask_r <= `CPL_MASK_RST;
        else if (wr_done && sel == `CPL_SEL_MASK)
            pixel_gate_mask_r <= wdata;
    end

    // [R5] Colour holding, upper bits dropped
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            red_hold_r <= 6'h00;
            grn_hold_r <= 6'h00;
        end
        else if (wr_done && sel == `CPL_SEL_PAL && color_phase_r == `CPL_PH_RED)
            red_hold_r <= wdata[5:0];
        else if (wr_done && sel == `CPL_SEL_PAL && color_phase_r == `CPL_PH_GRN)
            grn_hold_r <= wdata[5:0];
    end

    // [R2] Blue write stores joined entry
    always_ff @(posedge CLOCK)
    begin
        if (wr_done && sel == `CPL_SEL_PAL && phase_blue)
            palette_mem[palette_index_r] <= {red_hold_r, grn_hold_r, wdata[5:0]};
    end

    // [R4] Entry fetched between accesses in read mode, on red phase
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
            rd_word_r <= 18'h00000;
        else if (read_mode_r && rd_n_s && wr_n_s && color_phase_r == `CPL_PH_RED)
            rd_word_r <= palette_mem[palette_index_r];
    end

    // [R4] [R5] [R10] Read data mux and bus drive
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            rd_byte_r <= 8'h00;
            oe_n_r    <= 1'b1;
        end
        else
        begin
            if (rd_start)
            begin
                case (sel)
                    `CPL_SEL_IDX_RD: rd_byte_r <= palette_index_r;
                    `CPL_SEL_MASK:   rd_byte_r <= pixel_gate_mask_r;
                    `CPL_SEL_PAL:
                        case (color_phase_r)
                            `CPL_PH_RED: rd_byte_r <= {2'h0, rd_word_r[17:12]};
                            `CPL_PH_GRN: rd_byte_r <= {2'h0, rd_word_r[11:6]};
                            default:     rd_byte_r <= {2'h0, rd_word_r[5:0]};
                        endcase
                    default:         rd_byte_r <= palette_index_r;
                endcase
            end
            oe_n_r <= ~(~rd_n_s & wr_n_s);
        end
    end
    assign BUS.host_bus_to_host = rd_byte_r;
    assign BUS.host_bus_oe_n    = oe_n_r;

    // [R12] [R13] Pixel and blanking capture; [R14] mask; [R17] ignore when blank
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            pix_r     <= 8'h00;
            blank_n_r <= 1'b0;
        end
        else
        begin
            pix_r     <= BUS.blank_n ? (BUS.pixel_index_in & pixel_gate_mask_r) : 8'h00;
            blank_n_r <= BUS.blank_n;
        end
    end

    // [R20] Lookup stage with blanking delayed alike
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            look_r      <= 18'h00000;
            blank_n_d_r <= 1'b0;
        end
        else
        begin
            look_r      <= palette_mem[pix_r];
            blank_n_d_r <= blank_n_r;
        end
    end

    // [R16] Blank forces black
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            RED_CODE   <= 6'h00;
            GREEN_CODE <= 6'h00;
            BLUE_CODE  <= 6'h00;
        end
        else
        begin
            RED_CODE   <= blank_n_d_r ? look_r[17:12] : 6'h00;
            GREEN_CODE <= blank_n_d_r ? look_r[11:6]  : 6'h00;
            BLUE_CODE  <= blank_n_d_r ? look_r[5:0]   : 6'h00;
        end
    end
endmodule // cpl_device
`default_nettype wire

// File: logic/cpl_host.sv
// Host end: APB-commanded strobe sequencer driving the palette bus
`timescale 1ns/1ps
`default_nettype none
`include "cpl_cfg.svh"
module cpl_host
(
    input  wire logic        CLOCK,
    input  wire logic        SYS_RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [7:0]  PIXEL_IN,
    input  wire logic        BLANK_N_IN,
    cpl_if.host              BUS
);
    cpl_pkg::cpl_hst_e st_r;
    logic [2:0]  cnt_r;
    logic        op_rd_r;
    logic [1:0]  sel_r;
    logic [7:0]  wd_r;
    logic [7:0]  rdata_r;
    logic        rd_n_r;
    logic        wr_n_r;
    logic        busy;
    logic        acc;

    assign busy = (st_r != cpl_pkg::CPL_H_IDLE);
    assign acc  = PSEL & PENABLE;

    // APB answer in the access cycle, registered
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h00000000;
            PSLVERR <= 1'b0;
        end
        else
        begin
            PREADY  <= PSEL & ~PENABLE;
            PSLVERR <= PSEL & ~PENABLE & ~(PADDR == `CPL_APB_CMD || PADDR == `CPL_APB_STAT
                       || PADDR == `CPL_APB_RDATA);
            if (PSEL && !PENABLE && PADDR == `CPL_APB_STAT)
                PRDATA <= {31'h0, busy};
            else if (PSEL && !PENABLE && PADDR == `CPL_APB_RDATA)
                PRDATA <= {24'h0, rdata_r};
            else
                PRDATA <= 32'h00000000;
        end
    end

    // [R19] Strobe sequencer, never both low
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            st_r    <= cpl_pkg::CPL_H_IDLE;
            cnt_r   <= 3'h0;
            op_rd_r <= 1'b0;
            sel_r   <= 2'h0;
            wd_r    <= 8'h00;
            rd_n_r  <= 1'b1;
            wr_n_r  <= 1'b1;
            rdata_r <= 8'h00;
        end
        else
        begin
            case (st_r)
                cpl_pkg::CPL_H_IDLE:
                    if (acc && PREADY && PWRITE && PADDR == `CPL_APB_CMD)
                    begin
                        sel_r   <= PWDATA[9:8];
                        op_rd_r <= PWDATA[10];
                        wd_r    <= PWDATA[7:0];
                        cnt_r   <= `CPL_STROBE_CYC;
                        st_r    <= cpl_pkg::CPL_H_SETUP;
                    end
                cpl_pkg::CPL_H_SETUP:
                    if (cnt_r == 3'h0)
                    begin
                        rd_n_r <= ~op_rd_r;
                        wr_n_r <= op_rd_r;
                        cnt_r  <= `CPL_STROBE_CYC + `CPL_STROBE_CYC;
                        st_r   <= cpl_pkg::CPL_H_STROBE;
                    end
                    else
                        cnt_r <= cnt_r - 3'h1;
                cpl_pkg::CPL_H_STROBE:
                    if (cnt_r == 3'h0)
                    begin
                        if (op_rd_r)
                            rdata_r <= BUS.host_bus_to_host;
                        rd_n_r <= 1'b1;
                        wr_n_r <= 1'b1;
                        cnt_r  <= `CPL_STROBE_CYC + `CPL_STROBE_CYC;
                        st_r   <= cpl_pkg::CPL_H_HOLD;
                    end
                    else
                        cnt_r <= cnt_r - 3'h1;
                cpl_pkg::CPL_H_HOLD:
                    if (cnt_r == 3'h0)
                        st_r <= cpl_pkg::CPL_H_IDLE;
                    else
                        cnt_r <= cnt_r - 3'h1;
                default:
                    st_r <= cpl_pkg::CPL_H_IDLE;
            endcase
        end
    end

    assign BUS.target_select_lo = sel_r[0];
    assign BUS.target_select_hi = sel_r[1];
    assign BUS.rd_n             = rd_n_r;
    assign BUS.wr_n             = wr_n_r;
    assign BUS.host_bus_to_dev  = wd_r;
    assign BUS.pixel_index_in   = PIXEL_IN;
    assign BUS.blank_n          = BLANK_N_IN;
endmodule // cpl_host
`default_nettype wire

// File: testbench/cpl_monitor.sv
// Checker for the palette host bus and the pixel outputs
`timescale 1ns/1ps
`default_nettype none
`include "cpl_cfg.svh"
module cpl_monitor
(
    input wire logic       CLOCK,
    input wire logic       SYS_RST,
    input wire logic       target_select_lo,
    input wire logic       target_select_hi,
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic [7:0] host_bus_to_dev,
    input wire logic [7:0] host_bus_to_host,
    input wire logic       host_bus_oe_n,
    input wire logic       blank_n,
    input wire logic [5:0] RED_CODE,
    input wire logic [5:0] GREEN_CODE,
    input wire logic [5:0] BLUE_CODE
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    // Select lines joined as one code
    wire logic [1:0] sel = {target_select_hi, target_select_lo};

    a_strobes_exclusive: assert property (rd_n || wr_n)
        else $error("read and write strobes low together");
    a_write_data_held: assert property (
        !wr_n && !$past(wr_n) |-> $stable(host_bus_to_dev) && $stable(sel))
        else $error("write data or select moved under the strobe");
    a_write_strobe_width: assert property ($fell(wr_n) |-> !wr_n [*7] ##1 wr_n)
        else $error("write strobe width wrong");
    a_write_sel_hold: assert property ($rose(wr_n) |-> $stable(sel) [*3])
        else $error("select changed right after write strobe");
    a_read_strobe_width: assert property ($fell(rd_n) |-> ##7 $rose(rd_n))
        else $error("read strobe width wrong");
    a_oe_follows_read: assert property ($fell(rd_n) |-> ##[2:6] !host_bus_oe_n)
        else $error("device did not drive bus for a read");
    a_oe_releases: assert property ($rose(rd_n) |-> ##[2:6] host_bus_oe_n)
        else $error("device kept driving bus after read");
    a_oe_not_writing: assert property (!host_bus_oe_n |-> wr_n)
        else $error("device drives bus during a write");
    a_colour_upper_zero: assert property (
        !host_bus_oe_n && sel == `CPL_SEL_PAL |-> host_bus_to_host[7:6] == 2'h0)
        else $error("colour read upper bits not zero");
    a_blank_black: assert property (
        !$past(blank_n, 3) && !$past(blank_n, 4) |-> {RED_CODE, GREEN_CODE, BLUE_CODE} == 18'h0)
        else $error("blanked pixel not black");

    c_pal_write: cover property ($rose(wr_n) && sel == `CPL_SEL_PAL);
    c_pal_read: cover property (!host_bus_oe_n && sel == `CPL_SEL_PAL);
    c_blanked: cover property (!blank_n ##4 blank_n);
endmodule // cpl_monitor
`default_nettype wire

// File: testbench/color_palette_lookup_tb.sv
// Self-checking bench for the palette host and device pair
`timescale 1ns/1ps
`default_nettype none
`include "cpl_cfg.svh"
module color_palette_lookup_tb;
    logic        clock;
    logic        sys_rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  pixel;
    logic        blank_n;
    logic [5:0]  red;
    logic [5:0]  grn;
    logic [5:0]  blu;
    logic        err_seen;
    logic [31:0] tmp;
    logic [17:0] last_code;
    int          fail_count;
    int          samples_checked;

    cpl_if bus ();
    cpl_host u_cpl_host (.CLOCK(clock), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .PIXEL_IN(pixel), .BLANK_N_IN(blank_n), .BUS(bus));
    cpl_device u_cpl_device (.CLOCK(clock), .SYS_RST(sys_rst), .BUS(bus),
        .RED_CODE(red), .GREEN_CODE(grn), .BLUE_CODE(blu));
    cpl_monitor u_cpl_monitor (.CLOCK(clock), .SYS_RST(sys_rst),
        .target_select_lo(bus.target_select_lo), .target_select_hi(bus.target_select_hi),
        .rd_n(bus.rd_n), .wr_n(bus.wr_n), .host_bus_to_dev(bus.host_bus_to_dev),
        .host_bus_to_host(bus.host_bus_to_host), .host_bus_oe_n(bus.host_bus_oe_n),
        .blank_n(bus.blank_n), .RED_CODE(red), .GREEN_CODE(grn), .BLUE_CODE(blu));

    // Clock of 50 ns period
    always #25 clock = ~clock;

    // Verdict and end of run
    task automatic close_out;
        begin
            if (fail_count == 0 && samples_checked > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            samples_checked++;
            if (got !== exp)
            begin
                fail_count++;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    // One APB transfer, held until the ready edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        begin
            @(posedge clock);
            psel    <= 1'b1;
            penable <= 1'b0;
            pwrite  <= wr;
            paddr   <= a;
            pwdata  <= d;
            @(posedge clock);
            penable <= 1'b1;
            n = 0;
            do
            begin
                @(posedge clock);
                n++;
            end
            while (pready !== 1'b1 && n < 50);
            if (n >= 50)
            begin
                chk(32'h0, 32'h1);
                close_out();
            end
            q        = prdata;
            err_seen = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // One device access through the command register, waiting for idle
    task automatic dev(input logic [1:0] s, input logic rd, input logic [7:0] d,
                       output logic [7:0] q);
        logic [31:0] r;
        int          n;
        begin
            apb(1'b1, `CPL_APB_CMD, {21'h0, rd, s, d}, r);
            n = 0;
            do
            begin
                apb(1'b0, `CPL_APB_STAT, 32'h0, r);
                n++;
            end
            while (r[0] !== 1'b0 && n < 40);
            if (n >= 40)
            begin
                chk(32'h0, 32'h1);
                close_out();
            end
            apb(1'b0, `CPL_APB_RDATA, 32'h0, r);
            q = r[7:0];
        end
    endtask

    // Device write and checked device read
    task automatic put(input logic [1:0] s, input logic [7:0] d);
        logic [7:0] q;
        begin
            dev(s, 1'b0, d, q);
        end
    endtask

    task automatic get(input logic [1:0] s, input logic [7:0] e);
        logic [7:0] q;
        begin
            dev(s, 1'b1, 8'h00, q);
            chk({24'h0, q}, {24'h0, e});
        end
    endtask

    // Colour triplets to and from the palette
    task automatic put3(input logic [7:0] r, input logic [7:0] g, input logic [7:0] b);
        begin
            put(`CPL_SEL_PAL, r);
            put(`CPL_SEL_PAL, g);
            put(`CPL_SEL_PAL, b);
        end
    endtask

    task automatic get3(input logic [7:0] r, input logic [7:0] g, input logic [7:0] b);
        begin
            get(`CPL_SEL_PAL, r);
            get(`CPL_SEL_PAL, g);
            get(`CPL_SEL_PAL, b);
        end
    endtask

    // Drive a pixel; codes hold the old value two edges, show the new one at the third
    task automatic pix(input logic [7:0] p, input logic b, input logic [17:0] e);
        begin
            @(posedge clock);
            pixel   <= p;
            blank_n <= b;
            repeat (2) @(posedge clock);
            @(negedge clock);
            chk({14'h0, red, grn, blu}, {14'h0, last_code});
            @(posedge clock);
            @(negedge clock);
            chk({14'h0, red, grn, blu}, {14'h0, e});
            last_code = e;
        end
    endtask

    // Main sequence
    initial
    begin
        clock = 1'b0;
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pixel = 8'h00;
        blank_n = 1'b0;
        last_code = 18'h00000;
        err_seen = 1'b0;
        fail_count = 0;
        samples_checked = 0;
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        get(`CPL_SEL_IDX_RD, `CPL_IDX_RST);
        get(`CPL_SEL_MASK, `CPL_MASK_RST);
        apb(1'b0, 12'h0fc, 32'h0, tmp);
        chk({31'h0, err_seen}, 32'h1);
        put(`CPL_SEL_IDX_WR, 8'hfe);
        put3(8'hff, 8'h55, 8'haa);
        put3(8'h01, 8'h20, 8'h3e);
        get(`CPL_SEL_IDX_RD, 8'h00);
        put3(8'h07, 8'h08, 8'h09);
        get(`CPL_SEL_IDX_RD, 8'h01);
        put(`CPL_SEL_IDX_RD, 8'hfe);
        get3(8'h3f, 8'h15, 8'h2a);
        get3(8'h01, 8'h20, 8'h3e);
        get(`CPL_SEL_IDX_RD, 8'h00);
        put(`CPL_SEL_IDX_WR, 8'h10);
        put(`CPL_SEL_PAL, 8'h33);
        put(`CPL_SEL_IDX_WR, 8'h10);
        put3(8'h0a, 8'h0b, 8'h0c);
        put(`CPL_SEL_IDX_RD, 8'h10);
        get(`CPL_SEL_IDX_RD, 8'h10);
        get3(8'h0a, 8'h0b, 8'h0c);
        put(`CPL_SEL_IDX_WR, 8'h20);
        put(`CPL_SEL_PAL, 8'h11);
        get(`CPL_SEL_IDX_RD, 8'h20);
        put(`CPL_SEL_PAL, 8'h12);
        put(`CPL_SEL_PAL, 8'h13);
        put(`CPL_SEL_IDX_RD, 8'h20);
        get3(8'h11, 8'h12, 8'h13);
        pix(8'hfe, 1'b1, {6'h3f, 6'h15, 6'h2a});
        put(`CPL_SEL_MASK, 8'hfe);
        pix(8'hff, 1'b1, {6'h3f, 6'h15, 6'h2a});
        get(`CPL_SEL_MASK, 8'hfe);
        pix(8'hff, 1'b0, 18'h0);
        put(`CPL_SEL_MASK, 8'hff);
        pix(8'h00, 1'b1, {6'h07, 6'h08, 6'h09});
        close_out();
    end
endmodule // color_palette_lookup_tb
`default_nettype wire
